// File: core/adc_pin_control_config.sv
`timescale 1ns/1ps
module adc_pin_control_config
  import pin_cfg_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire reg_wr_t            regWr,
  input  wire logic [5:0]         regRdAddr,
  output logic      [15:0]        regRdData,
  input  wire logic               lineZeroData,
  input  wire logic               lineOneData,
  input  wire logic               lineZeroOutEn,
  input  wire logic               lineOneOutEn,
  input  wire logic               syncPinN,
  input  wire logic               faultPinIn,
  output logic                    faultPinOut,
  output logic                    faultPinOe,
  input  wire logic [2:0]         statusErrors,
  input  wire logic               otherErrors,
  output logic                    convErrorFlag,
  input  wire logic               altSyncMode,
  input  wire logic               multiChannel,
  input  wire logic               switchDue,
  input  wire logic [SEL_W-1:0]   nextChannel,
  input  wire logic [3:0]         channelPair,
  input  wire logic [DELAY_W-1:0] settleDelay,
  output logic [3:0]              analogPair,
  output sel_lines_t              selOut,
  output sel_lines_t              selOe,
  output logic                    modFilterReset,
  output logic                    convStart
);

  // ==========================================================
  // Configuration register
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic        wrHit;

  assign wrHit = regWr.wr && (regWr.addr == PIN_CFG_ADDR);
  // Reserved bits and low byte masked; bit 8 stored from writes
  assign cfg_d = wrHit ? (regWr.data & PIN_CFG_WMASK) : cfg_q;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg_q <= PIN_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // Field decode
  logic        extraEn;
  logic        muxCtrl;
  logic        syncEn;
  fault_mode_t faultMode;
  logic        faultLevel;

  assign extraEn    = cfg_q[EXTRA_EN_BIT];
  assign muxCtrl    = cfg_q[MUX_CTRL_BIT];
  assign syncEn     = cfg_q[SYNC_EN_BIT];
  assign faultMode  = fault_mode_t'(cfg_q[FAULT_MODE_HI:FAULT_MODE_LO]);
  assign faultLevel = cfg_q[FAULT_LVL_BIT];

  // ==========================================================
  // Pin synchronisers
  logic [1:0] syncMeta_q;
  logic [1:0] syncLvl_q;
  logic       syncPrev_q;
  logic [1:0] faultMeta_q;
  logic [1:0] faultLvl_q;

  // Metastability pair, then level pair; only the last stage feeds logic
  // Preset high like the idle pins, so no false rise follows reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      syncMeta_q  <= 2'h3;
      syncLvl_q   <= 2'h3;
      faultMeta_q <= 2'h3;
      faultLvl_q  <= 2'h3;
      syncPrev_q  <= 1'b1;
    end else begin
      syncMeta_q  <= {syncMeta_q[0], syncPinN};
      syncLvl_q   <= {syncLvl_q[0], syncMeta_q[1]};
      faultMeta_q <= {faultMeta_q[0], faultPinIn};
      faultLvl_q  <= {faultLvl_q[0], faultMeta_q[1]};
      syncPrev_q  <= syncLvl_q[1];
    end
  end

  logic syncHigh;
  logic syncRise;
  logic faultPinLvl;
  assign syncHigh    = syncLvl_q[1];
  assign syncRise    = syncHigh && !syncPrev_q;
  assign faultPinLvl = faultLvl_q[1];

  // ==========================================================
  // Channel switch sequencing
  seq_state_t         state_q;
  seq_state_t         state_d;
  logic [SEL_W-1:0]   sel_q;
  logic [DELAY_W-1:0] delayUnits_q;
  logic [11:0]        unitCnt_q;
  logic               altActive;
  logic               holdAtSwitch;
  logic               unitTick;
  logic               settleDone;
  logic               doSwitch;

  // Alternative mode only with several channels enabled
  assign altActive    = syncEn && altSyncMode && multiChannel;
  // Low sync at a due switch holds it
  assign holdAtSwitch = altActive && !syncHigh;
  // Zero delay ends at once; otherwise the last unit ends on its tick
  assign unitTick     = (unitCnt_q == DELAY_UNIT_CYC - 12'h001);
  assign settleDone   = (delayUnits_q == '0) || (unitTick && delayUnits_q == DELAY_W'(1));
  // Switch proceeds when due and not held, or when held and sync has risen
  assign doSwitch     = (state_q == SEQ_RUN && switchDue && !holdAtSwitch) ||
                        (state_q == SEQ_HOLD && syncRise);

  // Next state of the switch sequencer
  // A switch request outside the run state is ignored, not queued
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_RUN: begin
        if (switchDue) begin
          state_d = holdAtSwitch ? SEQ_HOLD : SEQ_SETTLE;
        end
      end
      SEQ_HOLD: begin
        if (syncRise) begin
          state_d = SEQ_SETTLE;
        end
      end
      SEQ_SETTLE: begin
        if (settleDone) begin
          state_d = SEQ_RUN;
        end
      end
      default: begin
        state_d = SEQ_RUN;
      end
    endcase
  end

  // Delay latched at the switch so a mid-wait change cannot stretch it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q      <= SEQ_RUN;
      sel_q        <= '0;
      delayUnits_q <= '0;
      unitCnt_q    <= '0;
    end else begin
      state_q <= state_d;
      if (doSwitch) begin
        // Code moves with the switch, before settling
        sel_q        <= nextChannel;
        delayUnits_q <= settleDelay;
        unitCnt_q    <= '0;
      end else if (state_q == SEQ_SETTLE) begin
        unitCnt_q <= unitTick ? 12'h000 : unitCnt_q + 12'h001;
        if (unitTick && delayUnits_q != '0) begin
          delayUnits_q <= delayUnits_q - DELAY_W'(1);
        end
      end
    end
  end

  // ==========================================================
  // Next values of the output registers
  logic        convStart_d;
  logic        resetHold_d;
  logic        faultOut_d;
  logic        faultOe_d;
  logic        anyStatusErr;
  logic        pinErrIn;
  logic        convError_d;
  sel_lines_t  muxOut;
  sel_lines_t  muxOe;
  sel_lines_t  userOut;
  sel_lines_t  userOe;
  sel_lines_t  selOut_d;
  sel_lines_t  selOe_d;
  logic        rdHit;
  logic        showPin;
  logic [15:0] rdData_d;

  // Plain mode: low sync holds modulator and filter
  assign resetHold_d = syncEn && !altActive && !syncHigh;
  // A start falling inside a plain-mode hold is dropped, not deferred
  assign convStart_d = (state_q == SEQ_SETTLE) && settleDone && !resetHold_d;

  // Errors ORed, inverted, open drain pulls low only
  assign anyStatusErr = |statusErrors;
  assign faultOut_d = (faultMode == FAULT_GP_OUT) ? faultLevel : 1'b0;
  assign faultOe_d  = (faultMode == FAULT_GP_OUT) ||
                      (faultMode == FAULT_OD_OUT && anyStatusErr);

  // Inverted pin joins other error sources
  assign pinErrIn    = (faultMode == FAULT_IN) && !faultPinLvl;
  assign convError_d = otherErrors || pinErrIn;

  // Four lines carry the select code in mux mode
  assign muxOut   = '{lineZero: sel_q[0], lineOne: sel_q[1], extraTwo: sel_q[2], extraThree: sel_q[3]};
  assign muxOe    = '{lineZero: 1'b1, lineOne: 1'b1, extraTwo: 1'b1, extraThree: 1'b1};
  // Extra outputs follow the enable bit; their data is tied low in this block
  assign userOut  = '{lineZero: lineZeroData, lineOne: lineOneData, extraTwo: 1'b0, extraThree: 1'b0};
  assign userOe   = '{lineZero: lineZeroOutEn, lineOne: lineOneOutEn, extraTwo: extraEn, extraThree: extraEn};
  assign selOut_d = muxCtrl ? muxOut : userOut;
  assign selOe_d  = muxCtrl ? muxOe : userOe;

  // Level bit reads the pin in input and open-drain modes
  assign rdHit    = (regRdAddr == PIN_CFG_ADDR);
  assign showPin  = (faultMode == FAULT_IN) || (faultMode == FAULT_OD_OUT);
  assign rdData_d = !rdHit  ? 16'h0000 :
                    showPin ? {cfg_q[15:9], faultPinLvl, 8'h00} : {cfg_q[15:8], 8'h00};

  // ==========================================================
  // Conversion control outputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      modFilterReset <= 1'b0;
      convStart      <= 1'b0;
    end else begin
      modFilterReset <= resetHold_d;
      convStart      <= convStart_d;
    end
  end

  // Fault pin drive and converter error flag
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      faultPinOut   <= 1'b0;
      faultPinOe    <= 1'b0;
      convErrorFlag <= 1'b0;
    end else begin
      faultPinOut   <= faultOut_d;
      faultPinOe    <= faultOe_d;
      convErrorFlag <= convError_d;
    end
  end

  // Pair selection untouched by mux mode
  // Host moves the pair between passes
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      analogPair <= '0;
    end else begin
      analogPair <= channelPair;
    end
  end

  // Pin lines; enables drop in reset so no line fights the board
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      selOut <= '0;
      selOe  <= '0;
    end else begin
      selOut <= selOut_d;
      selOe  <= selOe_d;
    end
  end

  // Read data one cycle after the address; other addresses read zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      regRdData <= '0;
    end else begin
      regRdData <= rdData_d;
    end
  end

endmodule

// File: inc/pin_cfg_pkg.sv
package pin_cfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [5:0]  PIN_CFG_ADDR  = 6'h06;
  localparam logic [15:0] PIN_CFG_RESET = 16'h0800;
  localparam logic [15:0] PIN_CFG_WMASK = 16'h3f00;

  // ==========================================================
  // Field positions
  localparam int EXTRA_EN_BIT  = 13;
  localparam int MUX_CTRL_BIT  = 12;
  localparam int SYNC_EN_BIT   = 11;
  localparam int FAULT_MODE_HI = 10;
  localparam int FAULT_MODE_LO = 9;
  localparam int FAULT_LVL_BIT = 8;

  // ==========================================================
  // Sequencer limits and timing
  localparam int          MUX_POSITIONS = 16;
  localparam int          SEL_W         = 4;
  localparam int          DELAY_W       = 3;
  localparam int          CLK_MHZ       = 25;
  localparam int          DELAY_UNIT_US = 4;
  localparam logic [11:0] DELAY_UNIT_CYC = 12'(DELAY_UNIT_US * CLK_MHZ);

  // ==========================================================
  // Fault pin modes
  typedef enum logic [1:0] {
    FAULT_OFF    = 2'h0,
    FAULT_IN     = 2'h1,
    FAULT_OD_OUT = 2'h2,
    FAULT_GP_OUT = 2'h3
  } fault_mode_t;

  // Sequencer states, Gray along the path except run to hold
  typedef enum logic [1:0] {
    SEQ_RUN    = 2'h0,
    SEQ_SETTLE = 2'h1,
    SEQ_HOLD   = 2'h3
  } seq_state_t;

  // Register write strobe group
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] data;
  } reg_wr_t;

  // Select lines toward the external multiplexer
  typedef struct packed {
    logic lineZero;
    logic lineOne;
    logic extraTwo;
    logic extraThree;
  } sel_lines_t;

endpackage

// File: tb/pin_cfg_monitor.sv
`timescale 1ns/1ps
// ======
// Port checker
module pin_cfg_monitor
  import pin_cfg_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               nrst,
  input wire reg_wr_t            regWr,
  input wire logic [5:0]         regRdAddr,
  input wire logic [15:0]        regRdData,
  input wire logic               switchDue,
  input wire logic [SEL_W-1:0]   nextChannel,
  input wire logic [DELAY_W-1:0] settleDelay,
  input wire logic               altSyncMode,
  input wire logic               modFilterReset,
  input wire logic               convStart,
  input wire sel_lines_t         selOut,
  input wire sel_lines_t         selOe,
  input wire logic               syncPinN,
  input wire logic               otherErrors,
  input wire logic               faultPinIn,
  input wire logic               convErrorFlag,
  input wire logic [3:0]         channelPair,
  input wire logic [3:0]         analogPair
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [3:0] code;
  // Last requested code; legal spacing means none is refused
  always_ff @(posedge core_clk) if (switchDue) code <= nextChannel;
  sequence s_cfgWr;
    regWr.wr && regWr.addr == PIN_CFG_ADDR && !regWr.data[MUX_CTRL_BIT];
  endsequence
  sequence s_sw(d);
    switchDue && settleDelay == d && !altSyncMode && !modFilterReset;
  endsequence
  property p_rdZero; regRdAddr != PIN_CFG_ADDR |=> regRdData == 16'h0000; endproperty
  property p_rsvd; regRdData[15:14] == 2'h0 && regRdData[7:0] == 8'h00; endproperty
  property p_extra;
    s_cfgWr ##1 !regWr.wr |=> selOe.extraTwo == $past(regWr.data[EXTRA_EN_BIT], 2) && selOe.extraThree == selOe.extraTwo;
  endproperty
  property p_code;
    convStart && selOe == 4'hf |-> {selOut.extraThree, selOut.extraTwo, selOut.lineOne, selOut.lineZero} == code;
  endproperty
  property p_fast; s_sw(3'h0) |-> ##2 convStart; endproperty
  property p_slow; s_sw(3'h1) |=> !convStart [*8] ##[91:95] convStart; endproperty
  property p_sync; $rose(modFilterReset) |-> !$past(syncPinN, 2); endproperty
  property p_errIn; (!otherErrors && faultPinIn) [*5] |=> !convErrorFlag; endproperty
  property p_pair; switchDue |=> analogPair == $past(channelPair); endproperty
  a_rdZero: assert property (p_rdZero) else $error("other address reads nonzero");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  a_extra: assert property (p_extra) else $error("extra outputs enable wrong");
  a_code: assert property (p_code) else $error("select code wrong at start");
  a_fast: assert property (p_fast) else $error("no start two cycles after switch");
  a_slow: assert property (p_slow) else $error("settling delay wrong");
  a_sync: assert property (p_sync) else $error("hold without low sync");
  a_errIn: assert property (p_errIn) else $error("error flag without cause");
  a_pair: assert property (p_pair) else $error("analog pair not passed");
endmodule

bind adc_pin_control_config pin_cfg_monitor mon_u (.*);

// File: tb/ext_mux_model.sv
`timescale 1ns/1ps
// ======
// Far side: mux, sync host, shared fault line
module ext_mux_model
  import pin_cfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        holdReq,
  input  wire logic        pullLow,
  input  wire logic        convStart,
  input  wire sel_lines_t  selOut,
  input  wire sel_lines_t  selOe,
  input  wire logic        faultPinOut,
  input  wire logic        faultPinOe,
  output logic             syncPinN,
  output logic             faultPinIn,
  output logic [3:0]       channelPair
);
  // Pull-up line, any party may pull low
  assign faultPinIn = (faultPinOe ? faultPinOut : 1'h1) && !pullLow;
  initial syncPinN = 1'h1;
  initial channelPair = 4'h0;
  always @(posedge core_clk) syncPinN <= #1 !holdReq;
  always @(posedge core_clk) if (convStart && selOe == 4'hf && selOut == 4'hf) channelPair <= #1 channelPair + 4'h1;
endmodule

// File: tb/adc_pin_control_config_test.sv
`timescale 1ns/1ps
// ======
// Bench top
module adc_pin_control_config_test;
  import pin_cfg_pkg::*;
  logic        core_clk = '0, nrst = '0, holdReq = '0, pullLow = '0, switchDue = '0;
  logic        altSyncMode = '0, multiChannel = '0, otherErrors = '0;
  logic        lineZeroData = '0, lineOneData = '0, lineZeroOutEn = '0, lineOneOutEn = '0;
  logic [2:0]  statusErrors = '0, settleDelay = '0;
  logic [3:0]  nextChannel = '0, channelPair, analogPair;
  logic [5:0]  regRdAddr = '0;
  logic [15:0] regRdData;
  logic        faultPinIn, faultPinOut, faultPinOe, convErrorFlag, modFilterReset, convStart, syncPinN;
  reg_wr_t     regWr = '0;
  sel_lines_t  selOut, selOe;
  int          err_total = 0, tests_run = 0, n;
  adc_pin_control_config dut_u (.*);
  ext_mux_model mdl_u (.*);
  always #20 core_clk = ~core_clk;
  // ======
  // Shared tasks; inputs move 1 ns after the edge
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] d, input logic [5:0] a = 6'h06);
    regWr = '{1'h1, a, d};
    tick(1);
    regWr.wr = 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    regRdAddr = a;
    tick(2);
    chk(regRdData, exp);
  endtask
  task automatic kick(input logic [3:0] c);
    nextChannel = c;
    switchDue = 1'h1;
    tick(1);
    switchDue = 1'h0;
    n = 1;
  endtask
  // Bounded wait for start, then judge latency and code
  task automatic waitConv(input logic [3:0] c, input int lo, hi);
    while (convStart !== 1'h1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h1);
    chk({selOut.extraThree, selOut.extraTwo, selOut.lineOne, selOut.lineZero}, c);
  endtask
  // ======
  // Scenarios
  task automatic t_regs;
    rd(6'h06, PIN_CFG_RESET);
    rd(6'h05, 16'h0000);
    wr(16'hffff);
    rd(6'h06, 16'h3f00);
    wr(16'h0000, 6'h07);
    rd(6'h06, 16'h3f00);
    wr(16'h2000);
    tick(1);
    chk(selOe, 16'h3);
    wr(16'h0000);
    tick(1);
    chk(selOe, 16'h0);
  endtask
  task automatic t_mux;
    wr(16'h3000);
    for (int i = 0; i < 16; i++) begin
      kick(i[3:0]);
      waitConv(i[3:0], 2, 2);
    end
    tick(2);
    chk(analogPair, 16'h1);
    settleDelay = 3'h1;
    kick(4'h5);
    waitConv(4'h5, 100, 103);
    settleDelay = 3'h0;
  endtask
  task automatic t_sync;
    wr(16'h0800);
    holdReq = 1'h1;
    tick(6);
    chk(modFilterReset, 16'h1);
    holdReq = 1'h0;
    altSyncMode = 1'h1;
    tick(6);
    chk(modFilterReset, 16'h0);
    holdReq = 1'h1;
    tick(6);
    chk(modFilterReset, 16'h1);
    holdReq = 1'h0;
    tick(6);
    wr(16'h1800);
    multiChannel = 1'h1;
    holdReq = 1'h1;
    tick(6);
    kick(4'h9);
    repeat (20) begin
      tick(1);
      chk(convStart, 16'h0);
    end
    holdReq = 1'h0;
    n = 1;
    waitConv(4'h9, 1, 8);
    altSyncMode = 1'h0;
  endtask
  task automatic t_fault;
    statusErrors = 3'h2;
    pullLow = 1'h1;
    for (int m = 0; m < 4; m++) begin
      wr({5'h00, m[1:0], 9'h100});
      tick(4);
      chk({faultPinOe, faultPinOut, convErrorFlag}, {m[1], m == 3, m == 1});
      rd(6'h06, {5'h00, m[1:0], m == 0 || m == 3, 8'h00});
    end
    statusErrors = 3'h0;
    pullLow = 1'h0;
    wr(16'h0400);
    tick(4);
    chk(faultPinOe, 16'h0);
    otherErrors = 1'h1;
    tick(2);
    chk(convErrorFlag, 16'h1);
    otherErrors = 1'h0;
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(6);
    nrst = 1'h1;
    t_regs;
    t_mux;
    t_sync;
    t_fault;
    final_report;
  end
  // Watchdog well past the expected run
  initial begin
    #2000000;
    err_total++;
    final_report;
  end
endmodule
